// ### dcc_config_cmd.v
// command decoder for the downconverter configuration registers
`timescale 1ns/1ps
`include "dcc_regs.vh"

module dcc_config_cmd #(
  parameter HAS_BACKPLANE = 1         // backplane-capable variant
) (
  input  wire        clk,                    // 200 MHz system clock
  input  wire        rst_b,                  // async reset, active low
  input  wire        rx_valid,               // pulse: host byte present
  input  wire [7:0]  rx_byte,                // host byte, address first
  input  wire        rd_req,                 // pulse: host reads one byte
  input  wire        rf_freq_change,         // pulse: rf frequency changed
  input  wire        nv_done,                // pulse: store finished
  output reg         rd_valid_q,             // pulse: read-back byte valid
  output reg  [7:0]  rd_byte_q,              // read-back byte
  output reg         resp_pending_q,         // a read-back byte is owed
  output reg         gain_tracking_enable_q, // gain tracking on
  output reg         amp_auto_control_q,     // amp may be changed
  output reg  [1:0]  linearity_priority_q,   // trade-off selection
  output reg  [7:0]  expected_input_level_q, // sign-magnitude dB
  output reg  [7:0]  expected_mixer_drive_q, // sign-magnitude dB
  output reg  [7:0]  expected_output_level_q,// sign-magnitude dB
  output reg  [7:0]  atten_q,                // computed attenuation
  output reg         rf_amp_on_q,            // computed amp state
  output reg         gain_applied_q,         // pulse: new gain state
  output reg         nv_store_q,             // pulse: save settings
  output reg         nv_busy_q,              // store in progress
  output reg         pd_all_q,               // whole device powered down
  output reg  [2:0]  pd_lo_q,                // oscillators 1..3 down
  output reg         pd_chain_q,             // signal chain down
  output reg         external_ref_lock_q,    // lock to external ref
  output reg         ref_port_output_on_q,   // reference out port on
  output reg         ref_output_rate_select_q, // 0 10 MHz, 1 100 MHz
  output reg         backplane_clock_export_q, // backplane clock out
  output reg  [15:0] osc_dac_word_q,         // reference oscillator dac
  output reg         osc_dac_load_q,         // pulse: dac update
  output reg         first_local_oscillator_out_q // 1 drives lo out port
);
  localparam ST_ADDR = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_EXEC = 2'd2;

  reg  [1:0]  state_q;
  reg  [7:0]  addr_q;
  reg  [2:0]  left_q;
  reg  [2:0]  cnt_q;
  reg  [39:0] pay_q;
  reg  [2:0]  len_d;
  reg         known_d;
  reg         freq_change_q;
  wire [7:0]  trk_atten;
  wire        trk_amp;
  wire        trk_applied;

  // payload length per address; low byte first
  always @* begin
    known_d = 1'b1;
    case (rx_byte)
      `DCC_ADDR_AUTO_GAIN:    len_d = `DCC_LEN_AUTO_GAIN;
      `DCC_ADDR_SAVE_DEFAULT: len_d = `DCC_LEN_SAVE_DEFAULT;
      `DCC_ADDR_STANDBY:      len_d = `DCC_LEN_STANDBY;
      `DCC_ADDR_REF_CLOCK:    len_d = `DCC_LEN_REF_CLOCK;
      `DCC_ADDR_OSC_TUNE:     len_d = `DCC_LEN_OSC_TUNE;
      `DCC_ADDR_OSC1_ROUTE:   len_d = `DCC_LEN_OSC1_ROUTE;
      default: begin
        len_d   = 3'h1;
        known_d = 1'b0;
      end
    endcase
  end

  dcc_gain_track u_track (
    .clk         (clk),
    .rst_b       (rst_b),
    .enable      (gain_tracking_enable_q),
    .amp_auto    (amp_auto_control_q),
    .lin_prio    (linearity_priority_q),
    .rf_level    (expected_input_level_q),
    .mix_level   (expected_mixer_drive_q),
    .if_level    (expected_output_level_q),
    .freq_change (freq_change_q),
    .atten_q     (trk_atten),
    .amp_on_q    (trk_amp),
    .applied_q   (trk_applied)
  );

  // frame receive and dispatch
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q                  <= ST_ADDR;
      addr_q                   <= 8'h00;
      left_q                   <= 3'h0;
      cnt_q                    <= 3'h0;
      pay_q                    <= 40'h0;
      gain_tracking_enable_q   <= 1'b0;
      amp_auto_control_q       <= 1'b0;
      linearity_priority_q     <= 2'h0;
      expected_input_level_q   <= 8'h00;
      expected_mixer_drive_q   <= 8'h00;
      expected_output_level_q  <= 8'h00;
      nv_store_q               <= 1'b0;
      pd_all_q                 <= 1'b0;
      pd_lo_q                  <= 3'h0;
      pd_chain_q               <= 1'b0;
      external_ref_lock_q      <= 1'b0;
      ref_port_output_on_q     <= 1'b0;
      ref_output_rate_select_q <= 1'b0;
      backplane_clock_export_q <= 1'b0;
      osc_dac_word_q           <= `DCC_RST_TUNE;
      osc_dac_load_q           <= 1'b0;
      first_local_oscillator_out_q <= 1'b0;
    end else begin
      nv_store_q     <= 1'b0;
      osc_dac_load_q <= 1'b0;
      case (state_q)
        ST_ADDR: if (rx_valid) begin
          addr_q  <= known_d ? rx_byte : 8'hff;
          left_q  <= len_d;
          cnt_q   <= 3'h0;
          pay_q   <= 40'h0;
          state_q <= ST_DATA;
        end
        ST_DATA: if (rx_valid) begin
          case (cnt_q)
            3'd0: pay_q[7:0]   <= rx_byte;
            3'd1: pay_q[15:8]  <= rx_byte;
            3'd2: pay_q[23:16] <= rx_byte;
            3'd3: pay_q[31:24] <= rx_byte;
            default: pay_q[39:32] <= rx_byte;
          endcase
          cnt_q <= cnt_q + 3'h1;
          if (left_q == 3'h1)
            state_q <= ST_EXEC;
          left_q <= left_q - 3'h1;
        end
        ST_EXEC: begin
          state_q <= ST_ADDR;
          // unused payload bits are never looked at
          case (addr_q)
            `DCC_ADDR_AUTO_GAIN: begin
              gain_tracking_enable_q <= pay_q[`DCC_AG_ENABLE];
              if (pay_q[`DCC_AG_LOAD]) begin
                amp_auto_control_q <= pay_q[`DCC_AG_AMP_AUTO];
                linearity_priority_q <=
                  pay_q[`DCC_AG_LIN_HI:`DCC_AG_LIN_LO];
                expected_input_level_q <=
                  pay_q[`DCC_AG_RF_HI:`DCC_AG_RF_LO];
                expected_mixer_drive_q <=
                  pay_q[`DCC_AG_MIX_HI:`DCC_AG_MIX_LO];
                expected_output_level_q <=
                  pay_q[`DCC_AG_IF_HI:`DCC_AG_IF_LO];
              end
            end
            `DCC_ADDR_SAVE_DEFAULT:
              nv_store_q <= 1'b1;
            `DCC_ADDR_STANDBY:
              case (pay_q[`DCC_SB_SEC_HI:`DCC_SB_SEC_LO])
                `DCC_SEC_ALL:   pd_all_q   <= pay_q[`DCC_SB_STATE];
                `DCC_SEC_OSC1:  pd_lo_q[0] <= pay_q[`DCC_SB_STATE];
                `DCC_SEC_OSC2:  pd_lo_q[1] <= pay_q[`DCC_SB_STATE];
                `DCC_SEC_OSC3:  pd_lo_q[2] <= pay_q[`DCC_SB_STATE];
                `DCC_SEC_CHAIN: pd_chain_q <= pay_q[`DCC_SB_STATE];
                default:        pd_all_q   <= pd_all_q;
              endcase
            `DCC_ADDR_REF_CLOCK: begin
              external_ref_lock_q      <= pay_q[`DCC_RC_LOCK];
              ref_port_output_on_q     <= pay_q[`DCC_RC_OUT_ON];
              ref_output_rate_select_q <= pay_q[`DCC_RC_RATE];
              backplane_clock_export_q <= (HAS_BACKPLANE != 0) &&
                                          pay_q[`DCC_RC_BACKPLANE];
            end
            `DCC_ADDR_OSC_TUNE: begin
              osc_dac_word_q <= pay_q[15:0];
              osc_dac_load_q <= 1'b1;
            end
            `DCC_ADDR_OSC1_ROUTE:
              first_local_oscillator_out_q <= pay_q[0];
            default: addr_q <= addr_q;
          endcase
        end
        default: state_q <= ST_ADDR;
      endcase
    end
  end

  // read-back byte, store busy, registered tracking outputs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_pending_q <= 1'b0;
      rd_valid_q     <= 1'b0;
      rd_byte_q      <= 8'h00;
      nv_busy_q      <= 1'b0;
      freq_change_q  <= 1'b0;
      atten_q        <= 8'h00;
      rf_amp_on_q    <= 1'b0;
      gain_applied_q <= 1'b0;
    end else begin
      freq_change_q  <= rf_freq_change;
      atten_q        <= trk_atten;
      rf_amp_on_q    <= trk_amp;
      gain_applied_q <= trk_applied;
      rd_valid_q     <= 1'b0;
      if (state_q == ST_EXEC)
        resp_pending_q <= 1'b1;
      else if (rd_req && resp_pending_q) begin
        resp_pending_q <= 1'b0;
        rd_valid_q     <= 1'b1;
        rd_byte_q      <= `DCC_READBACK_BYTE;
      end
      // a new store request wins over a done in the same cycle
      if (nv_store_q)
        nv_busy_q <= 1'b1;
      else if (nv_done)
        nv_busy_q <= 1'b0;
    end
  end
endmodule // dcc_config_cmd

// ### dcc_regs.vh
// register addresses, field positions, lengths and reset values
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
`define DCC_ADDR_AUTO_GAIN    8'h17
`define DCC_ADDR_SAVE_DEFAULT 8'h18
`define DCC_ADDR_STANDBY      8'h19
`define DCC_ADDR_REF_CLOCK    8'h1a
`define DCC_ADDR_OSC_TUNE     8'h1b
`define DCC_ADDR_OSC1_ROUTE   8'h1c
`define DCC_LEN_AUTO_GAIN     3'h5
`define DCC_LEN_SAVE_DEFAULT  3'h1
`define DCC_LEN_STANDBY       3'h1
`define DCC_LEN_REF_CLOCK     3'h1
`define DCC_LEN_OSC_TUNE      3'h3
`define DCC_LEN_OSC1_ROUTE    3'h1
`define DCC_AG_ENABLE         0
`define DCC_AG_LOAD           1
`define DCC_AG_AMP_AUTO       2
`define DCC_AG_LIN_HI         4
`define DCC_AG_LIN_LO         3
`define DCC_AG_RF_HI          15
`define DCC_AG_RF_LO          8
`define DCC_AG_MIX_HI         23
`define DCC_AG_MIX_LO         16
`define DCC_AG_IF_HI          31
`define DCC_AG_IF_LO          24
`define DCC_SB_STATE          0
`define DCC_SB_SEC_HI         3
`define DCC_SB_SEC_LO         1
`define DCC_SEC_ALL           3'h0
`define DCC_SEC_OSC1          3'h1
`define DCC_SEC_OSC2          3'h2
`define DCC_SEC_OSC3          3'h3
`define DCC_SEC_CHAIN         3'h4
`define DCC_RC_LOCK           0
`define DCC_RC_OUT_ON         1
`define DCC_RC_RATE           2
`define DCC_RC_BACKPLANE      3
`define DCC_RST_AG_CFG        5'h00
`define DCC_RST_LEVELS        24'h000000
`define DCC_RST_TUNE          16'h8000
`define DCC_READBACK_BYTE     8'h00
`endif

// ### dcc_gain_track.v
// gain tracking: recomputes attenuator and amp state on rf frequency change
`timescale 1ns/1ps
module dcc_gain_track (
  input  wire        clk,          // system clock
  input  wire        rst_b,        // async reset, active low
  input  wire        enable,       // gain tracking enable
  input  wire        amp_auto,     // amp may be changed
  input  wire [1:0]  lin_prio,     // linearity priority
  input  wire [7:0]  rf_level,     // sign-magnitude rf input level
  input  wire [7:0]  mix_level,    // sign-magnitude mixer level
  input  wire [7:0]  if_level,     // sign-magnitude output level
  input  wire        freq_change,  // pulse: rf frequency changed
  output reg  [7:0]  atten_q,      // attenuator setting, 0.25 dB lsb
  output reg         amp_on_q,     // rf amplifier on
  output reg         applied_q     // pulse: new state applied
);
  wire signed [8:0] rf_s;
  wire signed [8:0] mix_s;
  wire signed [8:0] if_s;
  reg  signed [9:0] back_off;
  reg  signed [9:0] gain_need;
  reg  signed [9:0] mix_margin;
  reg  signed [9:0] over_drive;
  reg  signed [9:0] atten_wide;
  reg  [7:0]        atten_d;
  reg               amp_d;

  // sign bit 1 means negative
  assign rf_s  = rf_level[7]  ? -{2'b00, rf_level[6:0]}
                              : {2'b00, rf_level[6:0]};
  assign mix_s = mix_level[7] ? -{2'b00, mix_level[6:0]}
                              : {2'b00, mix_level[6:0]};
  assign if_s  = if_level[7]  ? -{2'b00, if_level[6:0]}
                              : {2'b00, if_level[6:0]};

  // coarse model only; the real tables live in firmware
  // concatenations are unsigned: land differences in signed regs first
  always @* begin
    back_off   = {8'h00, lin_prio} <<< 1;
    gain_need  = {if_s[8], if_s} - {rf_s[8], rf_s};
    mix_margin = {mix_s[8], mix_s} - {rf_s[8], rf_s} + back_off;
    over_drive = {rf_s[8], rf_s} - {mix_s[8], mix_s} + back_off;
    atten_wide = over_drive <<< 2;
    if (mix_margin > 10'sd0)
      atten_d = 8'h00;
    else
      atten_d = atten_wide[7:0];
    amp_d = amp_on_q;
    if (amp_auto)
      amp_d = (gain_need > 10'sd0) && (lin_prio < 2'd2);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      atten_q   <= 8'h00;
      amp_on_q  <= 1'b0;
      applied_q <= 1'b0;
    end else begin
      applied_q <= 1'b0;
      if (enable && freq_change) begin
        atten_q   <= atten_d;
        amp_on_q  <= amp_d;
        applied_q <= 1'b1;
      end
    end
  end
endmodule // dcc_gain_track

// ### dcc_config_cmd_sva.sv
// assertions on the configuration command decoder ports
`timescale 1ns/1ps
module dcc_config_cmd_sva (
  input wire        clk,                          // system clock
  input wire        rst_b,                        // reset, active low
  input wire        rx_valid,                     // host byte strobe
  input wire        rd_req,                       // read request
  input wire        rf_freq_change,               // frequency change
  input wire        nv_done,                      // store finished
  input wire        rd_valid_q,                   // read-back strobe
  input wire [7:0]  rd_byte_q,                    // read-back byte
  input wire        resp_pending_q,               // byte owed
  input wire        gain_tracking_enable_q,       // tracking on
  input wire        amp_auto_control_q,           // amp may change
  input wire [7:0]  atten_q,                      // attenuation
  input wire        rf_amp_on_q,                  // amp state
  input wire        gain_applied_q,               // new gain pulse
  input wire        nv_store_q,                   // store pulse
  input wire        nv_busy_q,                    // store running
  input wire        first_local_oscillator_out_q, // route bit
  input wire [15:0] osc_dac_word_q,               // dac word
  input wire        osc_dac_load_q                // dac update pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RD_OWED: assert property (
    rd_valid_q |-> $past(resp_pending_q))
    else $error("read-back given with nothing owed");
  AST_RD_ZERO: assert property (
    rd_valid_q |-> rd_byte_q == 8'h00)
    else $error("read-back byte not zero");
  AST_RD_ANS: assert property (
    rd_req && resp_pending_q |-> ##[1:2] rd_valid_q)
    else $error("read-back not answered");
  AST_TRACK_ON: assert property (
    rf_freq_change && gain_tracking_enable_q |-> ##[1:4] gain_applied_q)
    else $error("gain not applied after frequency change");
  AST_AMP_HELD: assert property (
    $changed(rf_amp_on_q) |-> amp_auto_control_q)
    else $error("amp changed without auto control");
  AST_ATTEN_SRC: assert property (
    $changed(atten_q) |-> gain_applied_q)
    else $error("attenuation changed outside gain update");
  AST_STORE_BUSY: assert property (
    nv_store_q |=> nv_busy_q)
    else $error("store did not raise busy");
  AST_BUSY_HOLD: assert property (
    nv_busy_q && !nv_done |=> nv_busy_q)
    else $error("busy dropped before store finished");
  AST_ROUTE_CMD: assert property (
    $changed(first_local_oscillator_out_q) |-> $past(rx_valid, 2))
    else $error("route changed without a command");
  AST_DAC_LOAD: assert property (
    $changed(osc_dac_word_q) |-> osc_dac_load_q)
    else $error("dac word changed without an update pulse");
  COV_RD: cover property (rd_req && resp_pending_q ##1 rd_valid_q);
  COV_GAIN: cover property (gain_applied_q);
  COV_STORE: cover property (nv_busy_q ##1 !nv_busy_q);
endmodule // dcc_config_cmd_sva

// ### dcc_nv_model.sv
// nonvolatile store responder on the far side of the save command
`timescale 1ns/1ps
module dcc_nv_model #(
  parameter DELAY = 20 // cycles a store takes
) (
  input  wire clk,   // system clock
  input  wire rst_b, // reset, active low
  input  wire store, // pulse: store request
  output reg  done   // pulse: store finished
);
  reg [7:0] cnt_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      done  <= 1'b0;
    end else begin
      done <= (cnt_q == 8'h01);
      if (store)
        cnt_q <= DELAY[7:0];
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // dcc_nv_model

// ### downconverter_config_commands_bench.sv
// self-checking bench for the configuration command decoder
`timescale 1ns/1ps
module downconverter_config_commands_bench;
  reg clk = 1'b0, rst_b = 1'b0, rx_valid = 1'b0, rd_req = 1'b0;
  reg rf_freq_change = 1'b0;
  reg [7:0] rx_byte = 8'h00;
  wire nv_done, rd_valid_q, resp_pending_q, gte, aac, rf_amp_on_q, gain_applied_q;
  wire nv_store_q, nv_busy_q, pd_all_q, pd_chain_q, lock, out_on, rate, bp, lo_out;
  wire [1:0] lin;
  wire [2:0] pd_lo_q;
  wire [7:0] rd_byte_q, lvl_in, lvl_mix, lvl_out, atten_q;
  wire [15:0] osc_dac_word_q;
  integer mismatches = 0, check_count = 0, cycles = 0, i, n;
  reg [7:0] a_save;
  reg [4:0] pd_msk, pd_exp;
  dcc_config_cmd #(.HAS_BACKPLANE(1)) u_dut (.clk(clk), .rst_b(rst_b),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rd_req(rd_req),
    .rf_freq_change(rf_freq_change), .nv_done(nv_done),
    .rd_valid_q(rd_valid_q), .rd_byte_q(rd_byte_q), .resp_pending_q(resp_pending_q),
    .gain_tracking_enable_q(gte), .amp_auto_control_q(aac),
    .linearity_priority_q(lin), .expected_input_level_q(lvl_in),
    .expected_mixer_drive_q(lvl_mix), .expected_output_level_q(lvl_out),
    .atten_q(atten_q), .rf_amp_on_q(rf_amp_on_q), .gain_applied_q(gain_applied_q),
    .nv_store_q(nv_store_q), .nv_busy_q(nv_busy_q), .pd_all_q(pd_all_q),
    .pd_lo_q(pd_lo_q), .pd_chain_q(pd_chain_q), .external_ref_lock_q(lock),
    .ref_port_output_on_q(out_on), .ref_output_rate_select_q(rate),
    .backplane_clock_export_q(bp), .osc_dac_word_q(osc_dac_word_q),
    .osc_dac_load_q(), .first_local_oscillator_out_q(lo_out));
  dcc_nv_model #(.DELAY(20)) u_nv (.clk(clk), .rst_b(rst_b), .store(nv_store_q),
    .done(nv_done));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // address, then n payload bytes low first, then the owed read-back
  task send(input [7:0] addr, input [39:0] pl, input integer cnt);
    integer k;
    begin
      rx_valid = 1'b1;
      rx_byte = addr;
      tick;
      for (k = 0; k < cnt; k = k + 1) begin
        rx_byte = pl[8*k +: 8];
        tick;
      end
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tick;
      tick;
      rd_req = 1'b1;
      tick;
      rd_req = 1'b0;
      k = 0;
      while (rd_valid_q !== 1'b1 && k < 4) begin
        tick;
        k = k + 1;
      end
      chk({rd_valid_q, rd_byte_q}, 16'h0100);
      tick;
    end
  endtask
  task pulse_freq;
    begin
      rf_freq_change = 1'b1;
      tick;
      rf_freq_change = 1'b0;
      n = 0;
      repeat (6) begin
        tick;
        if (gain_applied_q === 1'b1)
          n = n + 1;
      end
    end
  endtask
  task close_out;
    begin
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(osc_dac_word_q, 16'h8000);
    for (i = 0; i < 4; i = i + 1) begin
      // byte 0: enable, load, amp auto off, linearity i
      send(8'h17, {8'h00, 8'h05 + i[7:0], 8'h8a,
        8'h13 + i[7:0], 3'h0, i[1:0], 3'h3}, 5);
      chk({gte, aac, lin}, {2'b10, i[1:0]});
      chk({lvl_in, lvl_mix}, {8'h13 + i[7:0], 8'h8a});
      chk(lvl_out, 8'h05 + i[7:0]);
    end
    send(8'h17, 40'h00_7f_22_33_01, 5);
    chk({lvl_in, lvl_mix}, 16'h168a);
    chk({gte, lin}, 3'b111);
    pulse_freq;
    chk(n, 1);
    chk(rf_amp_on_q, 1'b0);
    // gain needed with amp auto on, then amp auto off with gain to spare
    send(8'h17, 40'h00_14_00_8a_07, 5);
    pulse_freq;
    chk(rf_amp_on_q, 1'b1);
    send(8'h17, 40'h00_8a_00_14_03, 5);
    pulse_freq;
    chk({n[0], rf_amp_on_q}, 2'b11);
    send(8'h17, 40'h0, 5);
    a_save = atten_q;
    pulse_freq;
    chk(n, 0);
    chk(atten_q, a_save);
    send(8'h18, 40'h0, 1);
    chk(nv_busy_q, 1'b1);
    repeat (25) tick;
    chk(nv_busy_q, 1'b0);
    // section flags are independent: set all five, then clear them
    pd_exp = 5'h00;
    for (i = 0; i < 10; i = i + 1) begin
      n = i % 5;
      send(8'h19, {36'h0, n[2:0], i < 5}, 1);
      pd_msk = (n == 0) ? 5'h10 : (n == 4) ? 5'h01 : (5'h01 << n);
      pd_exp = (i < 5) ? (pd_exp | pd_msk) : (pd_exp & ~pd_msk);
      chk({pd_all_q, pd_lo_q, pd_chain_q}, pd_exp);
    end
    send(8'h1a, 40'h0f, 1);
    chk({bp, rate, out_on, lock}, 4'hf);
    send(8'h1a, 40'hf1, 1);
    chk({bp, rate, out_on, lock}, 4'h1);
    send(8'h1b, 40'h00beef, 3);
    chk(osc_dac_word_q, 16'hbeef);
    send(8'h1c, 40'h01, 1);
    chk(lo_out, 1'b1);
    send(8'h05, 40'h00, 1);
    chk(lo_out, 1'b1);
    send(8'h1c, 40'hfe, 1);
    chk(lo_out, 1'b0);
    close_out;
  end
endmodule // downconverter_config_commands_bench
bind dcc_config_cmd dcc_config_cmd_sva u_sva (.clk(clk), .rst_b(rst_b),
  .rx_valid(rx_valid), .rd_req(rd_req), .rf_freq_change(rf_freq_change),
  .nv_done(nv_done), .rd_valid_q(rd_valid_q), .rd_byte_q(rd_byte_q),
  .resp_pending_q(resp_pending_q),
  .gain_tracking_enable_q(gain_tracking_enable_q),
  .amp_auto_control_q(amp_auto_control_q), .atten_q(atten_q),
  .rf_amp_on_q(rf_amp_on_q), .gain_applied_q(gain_applied_q),
  .nv_store_q(nv_store_q), .nv_busy_q(nv_busy_q),
  .first_local_oscillator_out_q(first_local_oscillator_out_q),
  .osc_dac_word_q(osc_dac_word_q), .osc_dac_load_q(osc_dac_load_q));
